// [common/rcwl_pkg.sv]
// Constants for the reset-cause, watchdog and low-voltage block.
// Assumes a 32-bit APB register bus and a 24-bit program counter.
package rcwl_pkg;
  localparam int PC_W = 24;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WDOG = 8'h08;
  // Bit positions in reset_cause_control
  localparam int B_POR = 0;
  localparam int B_BROWN = 1;
  localparam int B_IDLE = 2;
  localparam int B_SLEEP = 3;
  localparam int B_WDOG_TO = 4;
  localparam int B_WDOG_EN = 5;
  localparam int B_SOFT_RST = 6;
  localparam int B_PIN_RST = 7;
  localparam int B_LV_SEL_LO = 8;
  localparam int B_LV_EN = 12;
  localparam int B_REF_OK = 13;
  localparam int B_IOP = 14;
  localparam int B_TRAP = 15;
  // Bits software may write; reference-stable is read only
  localparam logic [15:0] CTRL_WMASK = 16'hdfff;
  localparam logic [15:0] CTRL_RESET = 16'h0003;
  // Status register bits
  localparam int S_LVDEV = 0;
  localparam int S_CFGWD = 1;
  localparam int S_WDRUN = 2;
  localparam logic [PC_W-1:0] VEC_RESET = 24'h000000;
  localparam logic [PC_W-1:0] VEC_CLKFAIL = 24'h000004;
  localparam logic [PC_W-1:0] PC_STEP = 24'h000002;
  typedef enum logic [1:0] {PS_RUN, PS_IDLE, PS_SLEEP} rcwl_pstate_type;
endpackage

// [hdl/rcwl_reset_cause.sv]
// Reset-cause register, restart vector, watchdog, low-voltage detect
// control and power-save state, behind an APB slave.
// Assumes core events are one-cycle pulses on clk; pin and analog
// inputs arrive asynchronously and are synchronised here.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
module rcwl_reset_cause
  import rcwl_pkg::*;
#(
  parameter int WDT_BITS = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brownOut,
  input wire logic extResetPinN,
  input wire logic swResetReq,
  input wire logic trapLockup,
  input wire logic illegalOp,
  input wire logic clockFailTrap,
  input wire logic interruptWake,
  input wire logic [PC_W-1:0] intVector,
  input wire logic [PC_W-1:0] currentPc,
  input wire logic powerSaveExec,
  input wire logic powerSaveSleep,
  input wire logic clearWatchdog,
  input wire logic wdtRcClk,
  input wire logic configWatchdogEnable,
  input wire logic lowVoltageIn,
  input wire logic refStableIn,
  output logic deviceReset,
  output logic pcLoad,
  output logic [PC_W-1:0] pcValue,
  output logic inIdle,
  output logic inSleep,
  output logic lvdEnable,
  output logic [3:0] lvdThreshold
);
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic lvdEvent_reg;
  logic [WDT_BITS-1:0] wdCount_reg;
  rcwl_pstate_type pstate_reg;
  logic [1:0] pinSync_reg;
  logic [1:0] rcSync_reg;
  logic [1:0] cfgSync_reg;
  logic [1:0] lvSync_reg;
  logic [1:0] refSync_reg;
  logic pinLast_reg;
  logic rcLast_reg;
  logic pinFall;
  logic wdTick;
  logic wdRun;
  logic wdOverflow;
  logic wdReset;
  logic wdWake;
  logic busWr;
  logic busRd;
  logic ctrlWr;
  logic statWr;
  logic mapped;
  logic anyReset;
  logic anyWake;

  // Synchronisers: stage 0 is read only by stage 1
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinSync_reg <= 2'h3;
      rcSync_reg <= 2'h0;
      cfgSync_reg <= 2'h3;
      lvSync_reg <= 2'h0;
      refSync_reg <= 2'h0;
    end else begin
      pinSync_reg <= {pinSync_reg[0], extResetPinN};
      rcSync_reg <= {rcSync_reg[0], wdtRcClk};
      cfgSync_reg <= {cfgSync_reg[0], configWatchdogEnable};
      lvSync_reg <= {lvSync_reg[0], lowVoltageIn};
      refSync_reg <= {refSync_reg[0], refStableIn};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pinLast_reg <= 1'b1;
      rcLast_reg <= 1'b0;
    end else begin
      pinLast_reg <= pinSync_reg[1];
      rcLast_reg <= rcSync_reg[1];
    end
  end

  assign pinFall = pinLast_reg & ~pinSync_reg[1];
  assign wdTick = rcSync_reg[1] & ~rcLast_reg;

  assign wdRun = cfgSync_reg[1] | ctrl_reg[B_WDOG_EN];
  assign wdOverflow = wdRun & wdTick & (&wdCount_reg);
  assign wdReset = wdOverflow & (pstate_reg != PS_SLEEP);
  assign wdWake = wdOverflow & (pstate_reg == PS_SLEEP);

  assign anyReset = brownOut | pinFall | wdReset | swResetReq |
                    trapLockup | illegalOp;
  assign anyWake = wdWake | (interruptWake & (pstate_reg != PS_RUN));

  // Watchdog counter; cleared by instruction and by any device reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdCount_reg <= '0;
    end else if (clearWatchdog || anyReset || !wdRun) begin
      wdCount_reg <= '0;
    end else if (wdTick) begin
      wdCount_reg <= wdCount_reg + 1'b1;
    end
  end

  // APB decode: zero wait states, unmapped offsets answer with an error
  assign mapped = (paddr == OFS_CONTROL) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_WDOG);
  assign busWr = psel & penable & pwrite & mapped;
  assign busRd = psel & ~penable & ~pwrite;
  assign ctrlWr = busWr & (paddr == OFS_CONTROL);
  assign statWr = busWr & (paddr == OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Cause flags: a bus write lands first, hardware events then override
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrlWr) begin
      ctrl_next = (ctrl_reg & ~CTRL_WMASK) | (pwdata[15:0] & CTRL_WMASK);
    end
    if (brownOut) begin
      ctrl_next[B_BROWN] = 1'b1;
      ctrl_next[B_POR] = 1'b0;
    end else if (pinFall) begin
      ctrl_next[B_PIN_RST] = 1'b1;
      ctrl_next[B_WDOG_TO] = 1'b0;
      case (pstate_reg)
        PS_SLEEP: begin
          ctrl_next[B_SLEEP] = 1'b1;
          ctrl_next[B_IDLE] = 1'b0;
        end
        PS_IDLE: begin
          ctrl_next[B_IDLE] = 1'b1;
          ctrl_next[B_SLEEP] = 1'b0;
        end
        default: begin
          ctrl_next[B_SOFT_RST] = 1'b0;
          ctrl_next[B_IDLE] = 1'b0;
          ctrl_next[B_SLEEP] = 1'b0;
        end
      endcase
    end else if (wdReset) begin
      ctrl_next[B_WDOG_TO] = 1'b1;
      ctrl_next[B_PIN_RST] = 1'b0;
      ctrl_next[B_SOFT_RST] = 1'b0;
      ctrl_next[B_IDLE] = 1'b0;
      ctrl_next[B_SLEEP] = 1'b0;
    end else if (swResetReq) begin
      ctrl_next[B_SOFT_RST] = 1'b1;
      ctrl_next[B_PIN_RST] = 1'b0;
      ctrl_next[B_WDOG_TO] = 1'b0;
      ctrl_next[B_IDLE] = 1'b0;
      ctrl_next[B_SLEEP] = 1'b0;
    end else if (trapLockup || illegalOp) begin
      if (trapLockup) begin
        ctrl_next[B_TRAP] = 1'b1;
      end
      if (illegalOp) begin
        ctrl_next[B_IOP] = 1'b1;
      end
    end else if (wdWake) begin
      ctrl_next[B_WDOG_TO] = 1'b1;
      ctrl_next[B_SLEEP] = 1'b1;
    end else if (interruptWake && pstate_reg == PS_SLEEP) begin
      ctrl_next[B_SLEEP] = 1'b1;
    end else if (interruptWake && pstate_reg == PS_IDLE) begin
      ctrl_next[B_IDLE] = 1'b1;
    end
    ctrl_next[B_REF_OK] = refSync_reg[1];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign lvdThreshold = ctrl_reg[B_LV_SEL_LO +: 4];
  assign lvdEnable = ctrl_reg[B_LV_EN];

  // Low-voltage event: write one clears, a new detection wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lvdEvent_reg <= 1'b0;
    end else if (lvdEnable && lvSync_reg[1]) begin
      lvdEvent_reg <= 1'b1;
    end else if (statWr && pwdata[S_LVDEV]) begin
      lvdEvent_reg <= 1'b0;
    end
  end

  // Power-save state; any reset or wake returns to running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pstate_reg <= PS_RUN;
    end else if (anyReset || anyWake) begin
      pstate_reg <= PS_RUN;
    end else if (powerSaveExec && pstate_reg == PS_RUN) begin
      pstate_reg <= powerSaveSleep ? PS_SLEEP : PS_IDLE;
    end
  end

  assign inIdle = (pstate_reg == PS_IDLE);
  assign inSleep = (pstate_reg == PS_SLEEP);

  // Restart vector: the power-on reset itself loads zero while rstn is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      deviceReset <= 1'b1;
      pcLoad <= 1'b1;
      pcValue <= VEC_RESET;
    end else begin
      deviceReset <= anyReset;
      pcLoad <= anyReset | anyWake | clockFailTrap;
      if (anyReset) begin
        pcValue <= VEC_RESET;
      end else if (wdWake) begin
        pcValue <= currentPc + PC_STEP;
      end else if (interruptWake && pstate_reg != PS_RUN) begin
        pcValue <= intVector;
      end else if (clockFailTrap) begin
        pcValue <= VEC_CLKFAIL;
      end
    end
  end

  // Read data captured in the setup cycle, since pready never stalls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (busRd) begin
      case (paddr)
        OFS_CONTROL: prdata <= {16'h0000, ctrl_reg};
        OFS_STATUS: prdata <= {29'h00000000, wdRun, cfgSync_reg[1],
                               lvdEvent_reg};
        OFS_WDOG: prdata <= 32'(wdCount_reg);
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  property p_por_flags;
    @(posedge clk) $rose(rstn) |-> ctrl_reg[B_POR] && ctrl_reg[B_BROWN] &&
      pcLoad && pcValue == VEC_RESET;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on flags or vector wrong");

  property p_bor;
    @(posedge clk) disable iff (!rstn)
      brownOut |=> ctrl_reg[B_BROWN] && !ctrl_reg[B_POR] &&
      ctrl_reg[B_TRAP] == $past(ctrl_reg[B_TRAP]) && deviceReset;
  endproperty
  a_bor: assert property (p_bor)
    else $error("brown-out flags wrong");

  property p_pin_run;
    @(posedge clk) disable iff (!rstn)
      pinFall && !brownOut && pstate_reg == PS_RUN |=>
      ctrl_reg[B_PIN_RST] && !ctrl_reg[B_SOFT_RST] && !ctrl_reg[B_SLEEP] &&
      pcValue == VEC_RESET;
  endproperty
  a_pin_run: assert property (p_pin_run)
    else $error("pin reset flags wrong");

  property p_pin_sleep;
    @(posedge clk) disable iff (!rstn)
      pinFall && !brownOut && pstate_reg == PS_SLEEP |=>
      ctrl_reg[B_PIN_RST] && ctrl_reg[B_SLEEP] && !ctrl_reg[B_IDLE] &&
      ctrl_reg[B_SOFT_RST] == $past(ctrl_reg[B_SOFT_RST]);
  endproperty
  a_pin_sleep: assert property (p_pin_sleep)
    else $error("pin reset in sleep flags wrong");

  property p_sw;
    @(posedge clk) disable iff (!rstn)
      swResetReq && !brownOut && !pinFall && !wdReset |=>
      ctrl_reg[B_SOFT_RST] && !ctrl_reg[B_PIN_RST] && !ctrl_reg[B_WDOG_TO];
  endproperty
  a_sw: assert property (p_sw)
    else $error("software reset flags wrong");

  property p_wdwake;
    @(posedge clk) disable iff (!rstn)
      wdWake && !anyReset |=> pcLoad && !deviceReset &&
      pcValue == $past(currentPc) + PC_STEP && ctrl_reg[B_SLEEP] &&
      ctrl_reg[B_WDOG_TO] && pstate_reg == PS_RUN;
  endproperty
  a_wdwake: assert property (p_wdwake)
    else $error("watchdog wake wrong");

  property p_clkfail;
    @(posedge clk) disable iff (!rstn)
      clockFailTrap && !anyReset && !anyWake && !ctrlWr |=>
      pcValue == VEC_CLKFAIL && $stable(ctrl_reg[15:14]) &&
      $stable(ctrl_reg[7:0]);
  endproperty
  a_clkfail: assert property (p_clkfail)
    else $error("clock failure changed flags or vector");

  property p_wdcount;
    @(posedge clk) disable iff (!rstn)
      wdRun && wdTick && !clearWatchdog && !anyReset && !(&wdCount_reg)
      |=> wdCount_reg == $past(wdCount_reg) + 1'b1;
  endproperty
  a_wdcount: assert property (p_wdcount)
    else $error("watchdog did not count");

  property p_cfgen;
    @(posedge clk) disable iff (!rstn)
      cfgSync_reg[1] && wdTick && !clearWatchdog && !anyReset |=>
      wdCount_reg != $past(wdCount_reg);
  endproperty
  a_cfgen: assert property (p_cfgen)
    else $error("config enable did not force watchdog");

  property p_lvd;
    @(posedge clk) disable iff (!rstn)
      lvdEnable && lvSync_reg[1] |=> lvdEvent_reg;
  endproperty
  a_lvd: assert property (p_lvd)
    else $error("low-voltage event lost");

  property p_psave;
    @(posedge clk) disable iff (!rstn)
      powerSaveExec && pstate_reg == PS_RUN && !anyReset && !anyWake
      |=> inSleep == $past(powerSaveSleep) && inIdle != inSleep;
  endproperty
  a_psave: assert property (p_psave)
    else $error("power-save state wrong");
endmodule

// [sim/rcwl_core_model.sv]
// Core model: turns bench commands into one-cycle core event pulses.
// Assumes one command at a time, changed just after a clk edge.
`timescale 1ns/10ps
module rcwl_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [3:0] code,
  output logic brownOut,
  output logic swResetReq,
  output logic trapLockup,
  output logic illegalOp,
  output logic clockFailTrap,
  output logic interruptWake,
  output logic powerSaveExec,
  output logic powerSaveSleep,
  output logic clearWatchdog
);
  // Known low from time zero so no event fires before reset
  logic [8:0] hitReg = 9'h000;
  always @(posedge clk) begin
    if (!rstn)
      hitReg <= 9'h000;
    else
      hitReg <= go ? 9'h001 << code : 9'h000;
  end
  assign brownOut = hitReg[0];
  assign swResetReq = hitReg[1];
  assign trapLockup = hitReg[2];
  assign illegalOp = hitReg[3];
  assign clockFailTrap = hitReg[4];
  assign interruptWake = hitReg[5];
  assign powerSaveExec = hitReg[6] | hitReg[7];
  assign powerSaveSleep = hitReg[7];
  assign clearWatchdog = hitReg[8];
endmodule

// [sim/tb.sv]
// Bench for the reset-cause block: APB master, core model, pin and RC clock.
// Assumes zero-wait APB and one-cycle event pulses from the core model.
`timescale 1ns/10ps
module tb;
  import rcwl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, go = 1'b0;
  logic [3:0] code = 4'h0;
  logic brownOut, swResetReq, trapLockup, illegalOp, clockFailTrap;
  logic interruptWake, powerSaveExec, powerSaveSleep, clearWatchdog;
  logic extResetPinN = 1'b1, wdtRcClk = 1'b0, reset_cause_control = 1'b0;
  logic configWatchdogEnable = 1'b0, lowVoltageIn = 1'b0;
  logic refStableIn = 1'b1;
  logic [PC_W-1:0] intVector = 24'h000120, currentPc = 24'h0001f0;
  logic deviceReset, pcLoad, inIdle, inSleep, lvdEnable;
  logic [PC_W-1:0] pcValue;
  logic [3:0] lvdThreshold;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  always #12.5 clk = ~clk;
  // RC clock stands still unless a watchdog scenario needs it
  always #85 if (reset_cause_control) wdtRcClk = ~wdtRcClk;

  rcwl_reset_cause #(.WDT_BITS(4)) i_rcwl_reset_cause (.clk, .rstn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .brownOut, .extResetPinN, .swResetReq, .trapLockup, .illegalOp,
    .clockFailTrap, .interruptWake, .intVector, .currentPc, .powerSaveExec,
    .powerSaveSleep, .clearWatchdog, .wdtRcClk, .configWatchdogEnable,
    .lowVoltageIn, .refStableIn, .deviceReset, .pcLoad, .pcValue, .inIdle,
    .inSleep, .lvdEnable, .lvdThreshold);
  rcwl_core_model i_rcwl_core_model (.clk, .rstn, .go, .code, .brownOut,
    .swResetReq, .trapLockup, .illegalOp, .clockFailTrap, .interruptWake,
    .powerSaveExec, .powerSaveSleep, .clearWatchdog);

  task end_sim;
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task fire(input logic [3:0] c);
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // Codes 0..5 core events, 6 idle, 7 sleep, 9 pin, a watchdog
  task ev(input logic [3:0] c, ps, input logic [15:0] set, clr,
          input logic [PC_W-1:0] pcE, input logic rstE);
    logic [15:0] pre;
    for (int i = 0; i < 2; i++) begin
      pre = (i == 0) ? 16'hc0df : 16'h0000;
      if (c == 4'ha)
        pre[B_WDOG_EN] = 1'b1;
      apb(1'b1, OFS_CONTROL, {16'h0, pre});
      if (ps != 4'h0) begin
        fire(ps);
        repeat (2) @(negedge clk);
        chk("state", {30'h0, ps == 4'h7, ps == 4'h6},
            {30'h0, inSleep, inIdle});
        @(posedge clk);
      end
      if (c == 4'h9)
        extResetPinN <= 1'b0;
      else if (c == 4'ha)
        reset_cause_control = 1'b1;
      else
        fire(c);
      do @(negedge clk); while (pcLoad !== 1'b1);
      chk("pcValue", {8'h0, pcE}, {8'h0, pcValue});
      chk("deviceReset", {31'h0, rstE}, {31'h0, deviceReset});
      @(posedge clk);
      extResetPinN <= 1'b1;
      reset_cause_control = 1'b0;
      rdchk("control", OFS_CONTROL, {16'h0, (pre & ~clr) | set | 16'h2000});
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pcValue", 32'h0, {8'h0, pcValue});
    rdchk("control", OFS_CONTROL, 32'h2003);
    refStableIn <= 1'b0;
    apb(1'b1, OFS_CONTROL, 32'hfaff);
    rdchk("control", OFS_CONTROL, 32'hdaff);
    chk("lvdThreshold", 32'ha, {28'h0, lvdThreshold});
    chk("lvdEnable", 32'h1, {31'h0, lvdEnable});
    lowVoltageIn <= 1'b1;
    repeat (5) @(posedge clk);
    lowVoltageIn <= 1'b0;
    rdchk("status", OFS_STATUS, 32'h5);
    apb(1'b1, OFS_STATUS, 32'h1);
    rdchk("status", OFS_STATUS, 32'h4);
    apb(1'b1, OFS_CONTROL, 32'h0);
    refStableIn <= 1'b1;
    configWatchdogEnable <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("status", OFS_STATUS, 32'h6);
    reset_cause_control = 1'b1;
    repeat (20) @(posedge clk);
    apb(1'b0, OFS_WDOG, 32'h0);
    chk("cfgCount", 32'h1, {31'h0, rd != 32'h0});
    reset_cause_control = 1'b0;
    configWatchdogEnable <= 1'b0;
    rdchk("unmapped", 8'h0c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, OFS_CONTROL, 32'h20);
    reset_cause_control = 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_WDOG, 32'h0);
    chk("count", 32'h1, {31'h0, rd != 32'h0});
    fire(4'h8);
    apb(1'b0, OFS_WDOG, 32'h0);
    chk("cleared", 32'h1, {31'h0, rd[7:0] < 8'h2});
    reset_cause_control = 1'b0;
    ev(4'h0, 4'h0, 16'h0002, 16'h0001, VEC_RESET, 1'b1);
    ev(4'h1, 4'h0, 16'h0040, 16'h009c, VEC_RESET, 1'b1);
    ev(4'h9, 4'h0, 16'h0080, 16'h005c, VEC_RESET, 1'b1);
    ev(4'h9, 4'h7, 16'h0088, 16'h0014, VEC_RESET, 1'b1);
    ev(4'h9, 4'h6, 16'h0084, 16'h0018, VEC_RESET, 1'b1);
    ev(4'h2, 4'h0, 16'h8000, 16'h0000, VEC_RESET, 1'b1);
    ev(4'h3, 4'h0, 16'h4000, 16'h0000, VEC_RESET, 1'b1);
    ev(4'h4, 4'h0, 16'h0000, 16'h0000, VEC_CLKFAIL, 1'b0);
    ev(4'h5, 4'h7, 16'h0008, 16'h0000, intVector, 1'b0);
    ev(4'h5, 4'h6, 16'h0004, 16'h0000, intVector, 1'b0);
    ev(4'ha, 4'h0, 16'h0010, 16'h00cc, VEC_RESET, 1'b1);
    ev(4'ha, 4'h6, 16'h0010, 16'h00cc, VEC_RESET, 1'b1);
    ev(4'ha, 4'h7, 16'h0018, 16'h0000, 24'h0001f2, 1'b0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("control", OFS_CONTROL, 32'h2003);
    end_sim();
  end
endmodule
